// ---- rtl/dcir_defines.svh ----
/*
 dual core interrupt router: shared sizes, field positions and reset values.
 assumes inclusion by bare name from every file that needs these macros.
*/
// Overview of operation
// RQ1 - accept 175 sources and deliver interrupts and exceptions to both cores
// RQ2 - main core line n follows source n, no remapping
// RQ3 - secondary core gets eight lines, each fed by configurable source selection
// RQ4 - secondary core also gets eight software-only internal interrupts
// RQ5 - configurable priority: eight levels main core, four levels secondary core
// RQ6 - up to four sources selectable onto each core's non-maskable input, per core
// RQ7 - up to 45 sources can wake the device from deep sleep
// RQ8 - each core has its own wake unit requesting wake-up on enabled activity
// RQ9 - sixteen notify structures let one core interrupt the other
// RQ10 - one secondary line selector and its non-maskable input reserved for system
// RQ11 - a secondary line is the OR of its selected sources
// RQ12 - non-maskable input is four select fields, asserted when any selected source fires
`ifndef DCIR_DEFINES_SVH
`define DCIR_DEFINES_SVH

`define DCIR_NUM_SRC 175
`define DCIR_NUM_SEC 8
`define DCIR_SYS_LINE 7
`define DCIR_NUM_SW 8
`define DCIR_NUM_NMI 4
`define DCIR_NUM_WAKE 45
`define DCIR_NUM_NOTIFY 16
`define DCIR_MPRIO_W 3
`define DCIR_SPRIO_W 2
`define DCIR_SEL_W 8
`define DCIR_SEL_LIMIT 8'hAF
`define DCIR_RST_IRQ 1'b0
`define DCIR_RST_TOP_M 3'h0
`define DCIR_RST_TOP_S 2'h0

`endif

// ---- rtl/dcir_pkg.sv ----
/*
 types for the dual core interrupt router.
 assumes dcir_defines.svh is reachable on the include path.
*/
`default_nettype none
`include "dcir_defines.svh"
package dcir_pkg;
   typedef logic [`DCIR_NUM_SRC-1:0] dcir_src_t;
   typedef logic [`DCIR_NUM_SRC-1:0][`DCIR_MPRIO_W-1:0] dcir_mprio_t;
   typedef logic [`DCIR_NUM_SEC-1:0][`DCIR_SPRIO_W-1:0] dcir_sprio_t;
   typedef logic [`DCIR_SYS_LINE-1:0][`DCIR_NUM_SRC-1:0] dcir_app_map_t;
   typedef logic [`DCIR_NUM_NMI-1:0][`DCIR_SEL_W-1:0] dcir_nmi_sel_t;
   typedef logic [`DCIR_NUM_WAKE-1:0] dcir_wake_t;
   typedef enum logic [1:0] {DCIR_WAKE_IDLE, DCIR_WAKE_ARMED, DCIR_WAKE_REQ} dcir_wake_st_t;
endpackage
`default_nettype wire

// ---- rtl/dcir_wake_if.sv ----
/*
 carrier between the router and one core's wake unit.
 assumes one instance per core, all on the router clock.
*/
`default_nettype none
`include "dcir_defines.svh"
interface dcir_wake_if;
   logic deep_sleep;
   dcir_pkg::dcir_wake_t src;
   dcir_pkg::dcir_wake_t en;
   logic wake_req;
   modport unit (input deep_sleep, input src, input en, output wake_req);
   modport core (output deep_sleep, output src, output en, input wake_req);
endinterface
`default_nettype wire

// ---- rtl/dcir_wake_unit.sv ----
/*
 per-core wake unit: watches enabled wake sources while the core is in deep sleep.
 assumes deep_sleep and sources are synchronous to clk; request holds until sleep ends.
*/
`default_nettype none
`include "dcir_defines.svh"
module dcir_wake_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // core side
   dcir_wake_if.unit wif
);
   import dcir_pkg::*;

   dcir_wake_st_t st_q, st_d;
   logic req_q;
   wire hit = |(wif.src & wif.en);

   // armed one cycle after sleep entry so a stale request cannot fire at the border
   always_comb begin
      st_d = st_q;
      case (st_q)
         DCIR_WAKE_IDLE: begin
            if (wif.deep_sleep) st_d = DCIR_WAKE_ARMED;
         end
         DCIR_WAKE_ARMED: begin
            if (!wif.deep_sleep) st_d = DCIR_WAKE_IDLE;
            else if (hit) st_d = DCIR_WAKE_REQ; // see RQ8
         end
         DCIR_WAKE_REQ: begin
            if (!wif.deep_sleep) st_d = DCIR_WAKE_IDLE;
         end
         default: st_d = DCIR_WAKE_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= DCIR_WAKE_IDLE;
         req_q <= `DCIR_RST_IRQ;
      end else begin
         st_q <= st_d;
         req_q <= (st_d == DCIR_WAKE_REQ);
      end
   end

   assign wif.wake_req = req_q;
endmodule
`default_nettype wire

// ---- rtl/dcir_router.sv ----
/*
 dual core interrupt router top: main core lines, secondary core lines,
 software interrupts, non-maskable selection, priority levels, wake units, notify.
 assumes all sources and configuration inputs are synchronous to clk.
*/
`default_nettype none
`include "dcir_defines.svh"
module dcir_router (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // interrupt sources
   input wire dcir_pkg::dcir_src_t src_i,
   // main core configuration
   input wire dcir_pkg::dcir_mprio_t main_prio,
   input wire dcir_pkg::dcir_nmi_sel_t main_nmi_sel,
   input wire dcir_pkg::dcir_wake_t main_wake_en,
   input wire logic main_deep_sleep,
   // secondary core configuration
   input wire dcir_pkg::dcir_app_map_t sec_app_map,
   input wire dcir_pkg::dcir_src_t sec_sys_map,
   input wire dcir_pkg::dcir_sprio_t sec_prio,
   input wire dcir_pkg::dcir_nmi_sel_t sec_sys_nmi_sel,
   input wire dcir_pkg::dcir_wake_t sec_wake_en,
   input wire logic sec_deep_sleep,
   // secondary software interrupts
   input wire logic [`DCIR_NUM_SW-1:0] sw_set,
   input wire logic [`DCIR_NUM_SW-1:0] sw_clr,
   // notify structures
   input wire logic [`DCIR_NUM_NOTIFY-1:0] notify_set,
   input wire logic [`DCIR_NUM_NOTIFY-1:0] notify_clr,
   input wire logic [`DCIR_NUM_NOTIFY-1:0] notify_to_main,
   // main core outputs
   output logic [`DCIR_NUM_SRC-1:0] main_irq_q,
   output logic main_any_q,
   output logic [`DCIR_MPRIO_W-1:0] main_top_q,
   output logic main_nmi_q,
   output logic main_wake_q,
   // secondary core outputs
   output logic [`DCIR_NUM_SEC-1:0] sec_irq_q,
   output logic sec_any_q,
   output logic [`DCIR_SPRIO_W-1:0] sec_top_q,
   output logic [`DCIR_NUM_SW-1:0] sec_sw_q,
   output logic sec_nmi_q,
   output logic sec_wake_q,
   // notify outputs
   output logic [`DCIR_NUM_NOTIFY-1:0] notify_main_q,
   output logic [`DCIR_NUM_NOTIFY-1:0] notify_sec_q
);
   import dcir_pkg::*;

   localparam int NL_M = 1 << `DCIR_MPRIO_W;
   localparam int NL_S = 1 << `DCIR_SPRIO_W;

   logic [NL_M-1:0][`DCIR_NUM_SRC-1:0] mhit;
   logic [NL_M-1:0] mlvl;
   logic [NL_S-1:0][`DCIR_NUM_SEC-1:0] shit;
   logic [NL_S-1:0] slvl;
   logic [`DCIR_NUM_SEC-1:0] sec_line_d;
   logic [`DCIR_NUM_NMI-1:0] mnmi_hit;
   logic [`DCIR_NUM_NMI-1:0] snmi_hit;
   logic [`DCIR_MPRIO_W-1:0] mtop_d;
   logic [`DCIR_SPRIO_W-1:0] stop_d;
   logic [`DCIR_NUM_SW-1:0] sw_q;
   logic [`DCIR_NUM_NOTIFY-1:0] notify_q;
   wire [`DCIR_NUM_SW-1:0] sw_d = sw_set | (sw_q & ~sw_clr); // see RQ4
   wire [`DCIR_NUM_NOTIFY-1:0] notify_d = notify_set | (notify_q & ~notify_clr); // see RQ9

   // per-source level decode for the main core
   genvar n, l, k, f;
   generate
      for (l = 0; l < NL_M; l++) begin : g_mlvl
         for (n = 0; n < `DCIR_NUM_SRC; n++) begin : g_msrc
            assign mhit[l][n] = src_i[n] && (main_prio[n] == `DCIR_MPRIO_W'(l)); // see RQ5
         end
         assign mlvl[l] = |mhit[l];
      end
      // line 7 follows the system map only; application maps cover lines 0..6
      for (k = 0; k < `DCIR_NUM_SEC; k++) begin : g_sec
         if (k == `DCIR_SYS_LINE) begin : g_sys
            assign sec_line_d[k] = |(src_i & sec_sys_map); // see RQ10
         end else begin : g_app
            assign sec_line_d[k] = |(src_i & sec_app_map[k]); // see RQ3, see RQ11
         end
         for (l = 0; l < NL_S; l++) begin : g_slvl
            assign shit[l][k] = sec_line_d[k] && (sec_prio[k] == `DCIR_SPRIO_W'(l));
         end
      end
      for (l = 0; l < NL_S; l++) begin : g_sany
         assign slvl[l] = |shit[l];
      end
      // select value at or above the source count means field unused
      for (f = 0; f < `DCIR_NUM_NMI; f++) begin : g_nmi
         assign mnmi_hit[f] = (main_nmi_sel[f] < `DCIR_SEL_LIMIT) && src_i[main_nmi_sel[f]]; // see RQ12
         assign snmi_hit[f] = (sec_sys_nmi_sel[f] < `DCIR_SEL_LIMIT)
            && src_i[sec_sys_nmi_sel[f]]; // see RQ6, see RQ10
      end
   endgenerate

   // level 0 is most urgent
   always_comb begin
      mtop_d = `DCIR_RST_TOP_M;
      for (int i = NL_M - 1; i >= 0; i--) begin
         if (mlvl[i]) mtop_d = `DCIR_MPRIO_W'(i); // see RQ5
      end
   end

   always_comb begin
      stop_d = `DCIR_RST_TOP_S;
      for (int i = NL_S - 1; i >= 0; i--) begin
         if (slvl[i]) stop_d = `DCIR_SPRIO_W'(i); // see RQ5
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         main_irq_q <= '0;
         main_any_q <= `DCIR_RST_IRQ;
         main_top_q <= `DCIR_RST_TOP_M;
         main_nmi_q <= `DCIR_RST_IRQ;
      end else begin
         main_irq_q <= src_i; // see RQ1, see RQ2
         main_any_q <= |src_i;
         main_top_q <= mtop_d;
         main_nmi_q <= |mnmi_hit; // see RQ6
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sec_irq_q <= '0;
         sec_any_q <= `DCIR_RST_IRQ;
         sec_top_q <= `DCIR_RST_TOP_S;
         sec_nmi_q <= `DCIR_RST_IRQ;
      end else begin
         sec_irq_q <= sec_line_d; // see RQ1
         sec_any_q <= |sec_line_d;
         sec_top_q <= stop_d;
         sec_nmi_q <= |snmi_hit;
      end
   end

   // pending flags: a set in the clear cycle wins
   always_ff @(posedge clk) begin
      if (rst) begin
         sw_q <= '0;
         sec_sw_q <= '0;
         notify_q <= '0;
         notify_main_q <= '0;
         notify_sec_q <= '0;
      end else begin
         sw_q <= sw_d;
         sec_sw_q <= sw_d;
         notify_q <= notify_d;
         notify_main_q <= notify_d & notify_to_main; // see RQ9
         notify_sec_q <= notify_d & ~notify_to_main;
      end
   end

   // wake units; only the low sources can wake, the rest are not wired to the wake units
   dcir_wake_if wif_m ();
   dcir_wake_if wif_s ();
   assign wif_m.deep_sleep = main_deep_sleep;
   assign wif_m.src = src_i[`DCIR_NUM_WAKE-1:0]; // see RQ7
   assign wif_m.en = main_wake_en;
   assign wif_s.deep_sleep = sec_deep_sleep;
   assign wif_s.src = src_i[`DCIR_NUM_WAKE-1:0]; // see RQ7
   assign wif_s.en = sec_wake_en;
   assign main_wake_q = wif_m.wake_req;
   assign sec_wake_q = wif_s.wake_req;

   dcir_wake_unit u_wake_main (.clk(clk), .rst(rst), .wif(wif_m)); // see RQ8
   dcir_wake_unit u_wake_sec (.clk(clk), .rst(rst), .wif(wif_s));

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_sleep_hit_m;
      main_deep_sleep && |(src_i[`DCIR_NUM_WAKE-1:0] & main_wake_en);
   endsequence

   property p_main_direct;
      ##1 main_irq_q == $past(src_i);
   endproperty
   a_main_direct: assert property (p_main_direct) else $error("main line differs from source"); // see RQ2

   property p_sec_or;
      |(src_i & sec_app_map[0]) |=> sec_irq_q[0];
   endproperty
   a_sec_or: assert property (p_sec_or) else $error("selected source missing on line 0"); // see RQ11

   property p_sys_line;
      (src_i & sec_sys_map) == '0 |=> !sec_irq_q[`DCIR_SYS_LINE];
   endproperty
   a_sys_line: assert property (p_sys_line) else $error("system line raised by application map"); // see RQ10

   property p_sw_set;
      sw_set[0] && sw_clr[0] |=> sec_sw_q[0]
         ##1 (sec_sw_q[0] || $past(sw_clr[0]) && !$past(sw_set[0]));
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software interrupt lost on clear"); // see RQ4

   sequence s_notify_set_idle;
      notify_set[0] ##1 (!notify_clr[0] && !notify_set[0] && notify_to_main[0]);
   endsequence

   property p_notify_hold;
      s_notify_set_idle |=> notify_main_q[0];
   endproperty
   a_notify_hold: assert property (p_notify_hold) else $error("notify not held"); // see RQ9

   property p_main_nmi;
      main_nmi_sel[0] < `DCIR_SEL_LIMIT && src_i[main_nmi_sel[0]] |=> main_nmi_q;
   endproperty
   a_main_nmi: assert property (p_main_nmi) else $error("selected nmi source ignored"); // see RQ12

   property p_nmi_quiet;
      src_i == '0 |=> !main_nmi_q && !sec_nmi_q && !sec_any_q;
   endproperty
   a_nmi_quiet: assert property (p_nmi_quiet) else $error("nmi without source"); // see RQ6

   property p_top_zero;
      src_i[0] && main_prio[0] == '0 |=> main_any_q && main_top_q == '0;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("level zero not on top"); // see RQ5

   property p_wake;
      s_sleep_hit_m ##1 s_sleep_hit_m |=> main_wake_q;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake request in sleep"); // see RQ7

   property p_wake_awake;
      !main_deep_sleep |=> !main_wake_q;
   endproperty
   a_wake_awake: assert property (p_wake_awake) else $error("wake request while awake"); // see RQ8
endmodule
`default_nettype wire

// ---- testbench/dcir_core_model.sv ----
/*
 core stand-in: enters deep sleep on request, leaves it STALL+1 cycles after a wake.
 assumes the router clock and its synchronous reset.
*/
`default_nettype none
module dcir_core_model #(
   parameter int STALL = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench and router side
   input wire logic sleep_req,
   input wire logic wake_q,
   output logic deep_sleep
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sleep_q;
   logic [3:0] cnt_q;
   assign deep_sleep = sleep_q;
   // slow to answer on purpose, so the request must hold through the stall
   always_ff @(posedge clk) begin
      if (rst) begin
         sleep_q <= 1'b0;
         cnt_q <= 4'h0;
      end else if (sleep_req) begin
         sleep_q <= 1'b1;
      end else if (sleep_q && wake_q) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == 4'(STALL)) begin
            sleep_q <= 1'b0;
            cnt_q <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- testbench/dcir_router_test.sv ----
/*
 self-checking bench for the router, with one core stand-in per core.
 assumes the design files and dcir_defines.svh on the include path.
*/
`default_nettype none
`include "dcir_defines.svh"
module dcir_router_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dcir_pkg::*;
   logic clk;
   logic rst;
   dcir_src_t src_i;
   dcir_mprio_t main_prio;
   dcir_nmi_sel_t main_nmi_sel;
   dcir_nmi_sel_t sec_nmi_sel;
   dcir_wake_t main_wake_en;
   dcir_wake_t sec_wake_en;
   dcir_app_map_t sec_app_map;
   dcir_src_t sec_sys_map;
   dcir_sprio_t sec_prio;
   logic main_sleep;
   logic sec_sleep;
   logic sleep_req;
   logic [7:0] sw_set;
   logic [7:0] sw_clr;
   logic [15:0] notify_set;
   logic [15:0] notify_clr;
   logic [15:0] notify_to_main;
   logic [`DCIR_NUM_SRC-1:0] main_irq_q;
   logic [2:0] main_top_q;
   logic [7:0] sec_irq_q;
   logic [1:0] sec_top_q;
   logic [7:0] sec_sw_q;
   logic [15:0] notify_main_q;
   logic [15:0] notify_sec_q;
   logic main_any_q;
   logic main_nmi_q;
   logic main_wake_q;
   logic sec_any_q;
   logic sec_nmi_q;
   logic sec_wake_q;
   int failures;
   int total_checks;

   dcir_router dut (.clk(clk), .rst(rst), .src_i(src_i), .main_prio(main_prio),
      .main_nmi_sel(main_nmi_sel), .main_wake_en(main_wake_en), .main_deep_sleep(main_sleep),
      .sec_app_map(sec_app_map), .sec_sys_map(sec_sys_map), .sec_prio(sec_prio),
      .sec_sys_nmi_sel(sec_nmi_sel), .sec_wake_en(sec_wake_en), .sec_deep_sleep(sec_sleep),
      .sw_set(sw_set), .sw_clr(sw_clr), .notify_set(notify_set), .notify_clr(notify_clr),
      .notify_to_main(notify_to_main), .main_irq_q(main_irq_q), .main_any_q(main_any_q),
      .main_top_q(main_top_q), .main_nmi_q(main_nmi_q), .main_wake_q(main_wake_q),
      .sec_irq_q(sec_irq_q), .sec_any_q(sec_any_q), .sec_top_q(sec_top_q),
      .sec_sw_q(sec_sw_q), .sec_nmi_q(sec_nmi_q), .sec_wake_q(sec_wake_q),
      .notify_main_q(notify_main_q), .notify_sec_q(notify_sec_q));
   dcir_core_model main_core (.clk(clk), .rst(rst), .sleep_req(sleep_req),
      .wake_q(main_wake_q), .deep_sleep(main_sleep));
   dcir_core_model sec_core (.clk(clk), .rst(rst), .sleep_req(sleep_req),
      .wake_q(sec_wake_q), .deep_sleep(sec_sleep));

   task automatic check(input string what, input logic [174:0] seen, input logic [174:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // settle past the edge before looking
   task automatic tick();
      @(posedge clk);
      #1;
   endtask

   task automatic t_lines();
      dcir_src_t s;
      s = 175'h8 | (175'h1 << 100);
      @(posedge clk);
      src_i <= s;
      main_prio[0] <= 3'h0;
      main_prio[3] <= 3'h5;
      main_prio[100] <= 3'h2;
      sec_app_map[0][3] <= 1'b1;
      sec_app_map[5][100] <= 1'b1;
      sec_sys_map[174] <= 1'b1;
      sec_prio[0] <= 2'h3;
      sec_prio[5] <= 2'h1;
      tick();
      check("main_irq", main_irq_q, s);
      check("main_any", 175'(main_any_q), 175'h1);
      check("main_top", 175'(main_top_q), 175'h2);
      check("sec_irq", 175'(sec_irq_q), 175'h21);
      check("sec_any", 175'(sec_any_q), 175'h1);
      check("sec_top", 175'(sec_top_q), 175'h1);
      @(posedge clk);
      src_i <= 175'h1 << 174;
      tick();
      check("sec_sys", 175'(sec_irq_q), 175'h80);
      check("main_top", 175'(main_top_q), 175'h7);
      $display("lines done");
   endtask

   task automatic t_nmi();
      @(posedge clk);
      main_nmi_sel <= {8'hB0, 8'hFF, 8'hAF, 8'h0A};
      sec_nmi_sel <= {8'hFF, 8'hFF, 8'hAF, 8'h0B};
      src_i <= ~(175'hC00);
      tick();
      check("nmi_off", 175'({main_nmi_q, sec_nmi_q}), 175'h0);
      check("main_top0", 175'(main_top_q), 175'h0);
      @(posedge clk);
      src_i <= 175'h400;
      tick();
      check("nmi_main", 175'({main_nmi_q, sec_nmi_q}), 175'h2);
      @(posedge clk);
      src_i <= 175'h800;
      tick();
      check("nmi_sec", 175'({main_nmi_q, sec_nmi_q}), 175'h1);
      $display("nmi done");
   endtask

   task automatic t_sw();
      @(posedge clk);
      sw_set <= 8'h81;
      @(posedge clk);
      sw_set <= 8'h01;
      sw_clr <= 8'h81;
      #1;
      check("sw_set", 175'(sec_sw_q), 175'h81);
      @(posedge clk);
      sw_set <= 8'h00;
      sw_clr <= 8'h01;
      #1;
      check("sw_both", 175'(sec_sw_q), 175'h01);
      @(posedge clk);
      sw_clr <= 8'h00;
      #1;
      check("sw_clr", 175'(sec_sw_q), 175'h0);
      $display("software done");
   endtask

   task automatic t_notify();
      @(posedge clk);
      notify_set <= 16'h8021;
      notify_to_main <= 16'h0021;
      tick();
      check("notify", 175'({notify_main_q, notify_sec_q}), 175'h0021_8000);
      @(posedge clk);
      notify_set <= 16'h0000;
      notify_to_main <= 16'h8001;
      tick();
      check("notify_swap", 175'({notify_main_q, notify_sec_q}), 175'h8001_0020);
      @(posedge clk);
      notify_clr <= 16'hFFFF;
      tick();
      check("notify_clr", 175'({notify_main_q, notify_sec_q}), 175'h0);
      @(posedge clk);
      notify_clr <= 16'h0000;
      $display("notify done");
   endtask

   task automatic t_wake();
      int n;
      @(posedge clk);
      src_i <= '0;
      main_wake_en <= 45'h10;
      sec_wake_en <= 45'h1 << 44;
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      repeat (3) @(posedge clk);
      // 50 cannot wake, 5 is not enabled anywhere
      src_i <= (175'h1 << 50) | 175'h20;
      repeat (3) tick();
      check("no_wake", 175'({main_wake_q, sec_wake_q}), 175'h0);
      @(posedge clk);
      src_i <= 175'h10 | (175'h1 << 44);
      for (n = 0; n < 4 && {main_wake_q, sec_wake_q} !== 2'b11; n++) tick();
      check("wake", 175'({main_wake_q, sec_wake_q}), 175'h3);
      @(posedge clk);
      src_i <= '0;
      for (n = 0; n < 12 && {main_wake_q, sec_wake_q} !== 2'b00; n++) tick();
      check("wake_end", 175'({main_wake_q, sec_wake_q}), 175'h0);
      $display("wake done");
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial begin
      failures = 0;
      total_checks = 0;
      rst = 1'b1;
      src_i = '0;
      main_prio = '1;
      main_nmi_sel = '1;
      sec_nmi_sel = '1;
      main_wake_en = '0;
      sec_wake_en = '0;
      sec_app_map = '0;
      sec_sys_map = '0;
      sec_prio = '1;
      sleep_req = 1'b0;
      sw_set = '0;
      sw_clr = '0;
      notify_set = '0;
      notify_clr = '0;
      notify_to_main = '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_lines();
      t_nmi();
      t_sw();
      t_notify();
      t_wake();
      give_verdict();
   end
endmodule
`default_nettype wire
